// ---- core/fsc_pkg.sv ----
// Constants, frame carriers and states for the flash store command interpreter.
// Assumes every user includes nothing and writes fsc_pkg::name at each use.
package fsc_pkg;

  localparam logic [15:0] CLUSTER_MEMORY   = 16'h0023;
  localparam logic [7:0]  ENDPOINT_DATA    = 8'hE6;

  localparam logic [7:0]  CMD_GEOMETRY     = 8'h00;
  localparam logic [7:0]  CMD_GEOMETRY_RSP = 8'h80;
  localparam logic [7:0]  RSP_ID_FLAG      = 8'h80;

  localparam logic [7:0]  STATUS_OK        = 8'h00;
  localparam logic [7:0]  STATUS_FAIL      = 8'h01;

  localparam logic [15:0] BLOCK_COUNT      = 16'h0077;
  localparam logic [15:0] BLOCK_SIZE       = 16'h0200;
  localparam logic [15:0] ZERO_COUNT       = 16'h0000;

  localparam int          STORE_DEPTH      = 119 * 512;
  localparam int          BLOCK_BITS       = 7;
  localparam int          INDEX_BITS       = 9;
  localparam int          ADDR_BITS        = BLOCK_BITS + INDEX_BITS;

  localparam int          HDR_BYTES        = 8;
  localparam logic [3:0]  HDR_LEN          = 4'h8;
  localparam logic [3:0]  RSP_LEN          = 4'h8;
  localparam logic [3:0]  ONE_LEFT         = 4'h1;
  localparam int          OFS_CMD          = 0;
  localparam int          OFS_OPT          = 1;
  localparam int          OFS_BLK_HI       = 2;
  localparam int          OFS_BLK_LO       = 3;
  localparam int          OFS_IDX_HI       = 4;
  localparam int          OFS_IDX_LO       = 5;

  // Addressing that travels with an incoming frame
  typedef struct packed {
    logic [15:0] cluster;
    logic [7:0]  dstEndpoint;
    logic [7:0]  srcEndpoint;
    logic        broadcast;
  } fsc_req_meta_s;

  // Addressing that travels with an outgoing response
  typedef struct packed {
    logic [15:0] cluster;
    logic [7:0]  dstEndpoint;
    logic [7:0]  srcEndpoint;
    logic        indicatorFrame;
  } fsc_rsp_meta_s;

  typedef enum logic [0:0] {
    ST_RECEIVE,
    ST_SEND
  } fsc_state_e;

endpackage

// ---- core/fsc_store.sv ----
// Non-volatile user store: 119 blocks of 512 bytes, one byte port.
// Assumes a synchronous active-high reset; contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module fsc_store (
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  input  wire logic                            wrEn,
  input  wire logic [fsc_pkg::BLOCK_BITS-1:0]  block,
  input  wire logic [fsc_pkg::INDEX_BITS-1:0]  index,
  input  wire logic [7:0]                      wrData,
  output logic      [7:0]                      rdData,
  output logic                                 addrValid
);

  logic [7:0]                    mem [0:fsc_pkg::STORE_DEPTH-1];
  logic [fsc_pkg::ADDR_BITS-1:0] addr;
  logic                          inRange;

  // Block size is a power of two, so concatenation is block * size + index
  assign addr    = {block, index};
  assign inRange = ({9'h000, block} < fsc_pkg::BLOCK_COUNT);

  always_ff @(posedge core_clk) begin
    if (wrEn && inRange) begin
      mem[addr] <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData    <= 8'h00;
      addrValid <= 1'b0;
    end else begin
      rdData    <= inRange ? mem[addr] : 8'h00;
      addrValid <= inRange;
    end
  end

endmodule
`default_nettype wire

// ---- core/fsc_cmd_access.sv ----
// Command interpreter for the user flash store, fed by addressed frames.
// Assumes request bytes arrive one per accepted beat, most significant first,
// with frame addressing steady on the first beat of each frame.
//
// Overview of operation
// - Provide 119 blocks of 512 bytes, readable and writable by the application.
// - Commands are taken only on cluster 0x23, endpoint 0xE6 of this node.
// - Multi-byte request and response fields travel most significant byte first.
// - Unicast commands get a unicast response to the request's source endpoint.
// - Broadcast commands execute but produce no response.
// - Indicator framing when source endpoint 0xE6 or explicit mode, with frame mode.
// - Response mirrors request: response id, status, fields, byte count.
// - Status bit 0 set on failure, clear on success; other bits zero.
// - Geometry reply id 0x80, block field block count, index field block size.
// - Geometry reply carries byte count zero and no data.
`timescale 1ns/1ps
`default_nettype none
module fsc_cmd_access (
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  // Incoming command frames
  input  wire logic                            reqValid,
  input  wire logic [7:0]                      reqData,
  input  wire logic                            reqLast,
  input  wire fsc_pkg::fsc_req_meta_s          reqMeta,
  output logic                                 reqReady,
  // Node configuration
  input  wire logic                            explicitMode,
  input  wire logic                            frameMode,
  // Outgoing responses
  output logic                                 rspValid,
  output logic [7:0]                           rspData,
  output logic                                 rspLast,
  output fsc_pkg::fsc_rsp_meta_s               rspMeta,
  input  wire logic                            rspReady,
  // Application port to the store
  input  wire logic                            appWrEn,
  input  wire logic [fsc_pkg::BLOCK_BITS-1:0]  appBlock,
  input  wire logic [fsc_pkg::INDEX_BITS-1:0]  appIndex,
  input  wire logic [7:0]                      appWrData,
  output logic      [7:0]                      appRdData,
  output logic                                 appAddrValid
);

  fsc_pkg::fsc_state_e    state_q;
  fsc_pkg::fsc_req_meta_s meta_q;
  fsc_pkg::fsc_req_meta_s metaNow;
  logic [3:0]             hdrCnt_q;
  logic [7:0]             hdr_q   [0:fsc_pkg::HDR_BYTES-1];
  logic [7:0]             hdrNext [0:fsc_pkg::HDR_BYTES-1];
  logic [63:0]            rsp_q;
  logic [63:0]            rspBuild;
  logic [3:0]             rspLeft_q;
  logic                   reqBeat;
  logic                   frameEnd;
  logic                   forUs;
  logic                   answer;
  logic                   rspBeat;

  assign reqReady = (state_q == fsc_pkg::ST_RECEIVE);
  assign reqBeat  = reqValid && reqReady;
  assign frameEnd = reqBeat && reqLast;
  assign rspValid = (state_q == fsc_pkg::ST_SEND);
  assign rspBeat  = rspValid && rspReady;
  assign rspData  = rsp_q[63:56];
  assign rspLast  = rspValid && (rspLeft_q == fsc_pkg::ONE_LEFT);

  // First beat carries the addressing; later beats use the captured copy
  assign metaNow = (hdrCnt_q == 4'h0) ? reqMeta : meta_q;
  assign forUs   = (metaNow.cluster == fsc_pkg::CLUSTER_MEMORY) &&
                   (metaNow.dstEndpoint == fsc_pkg::ENDPOINT_DATA);
  assign answer  = forUs && !metaNow.broadcast;

  // Header image including the byte on the wire this cycle
  always_comb begin
    for (int i = 0; i < fsc_pkg::HDR_BYTES; i++) begin
      hdrNext[i] = hdr_q[i];
    end
    if (reqBeat && (hdrCnt_q < fsc_pkg::HDR_LEN)) begin
      hdrNext[hdrCnt_q[2:0]] = reqData;
    end
  end

  // Response image, most significant byte first
  always_comb begin
    if (hdrNext[fsc_pkg::OFS_CMD] == fsc_pkg::CMD_GEOMETRY) begin
      rspBuild = {fsc_pkg::CMD_GEOMETRY_RSP, fsc_pkg::STATUS_OK,
                  fsc_pkg::BLOCK_COUNT, fsc_pkg::BLOCK_SIZE,
                  fsc_pkg::ZERO_COUNT};
    end else begin
      rspBuild = {hdrNext[fsc_pkg::OFS_CMD] | fsc_pkg::RSP_ID_FLAG, fsc_pkg::STATUS_FAIL,
                  hdrNext[fsc_pkg::OFS_BLK_HI], hdrNext[fsc_pkg::OFS_BLK_LO],
                  hdrNext[fsc_pkg::OFS_IDX_HI], hdrNext[fsc_pkg::OFS_IDX_LO],
                  fsc_pkg::ZERO_COUNT};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= fsc_pkg::ST_RECEIVE;
    end else begin
      case (state_q)
        fsc_pkg::ST_RECEIVE: begin
          if (frameEnd && answer) begin
            state_q <= fsc_pkg::ST_SEND;
          end
        end
        fsc_pkg::ST_SEND: begin
          if (rspBeat && (rspLeft_q == fsc_pkg::ONE_LEFT)) begin
            state_q <= fsc_pkg::ST_RECEIVE;
          end
        end
        default: begin
          state_q <= fsc_pkg::ST_RECEIVE;
        end
      endcase
    end
  end

  // Header capture; short frames leave missing bytes at zero
  always_ff @(posedge core_clk) begin
    if (rst || frameEnd) begin
      hdrCnt_q <= 4'h0;
      for (int i = 0; i < fsc_pkg::HDR_BYTES; i++) begin
        hdr_q[i] <= 8'h00;
      end
    end else if (reqBeat) begin
      if (hdrCnt_q < fsc_pkg::HDR_LEN) begin
        hdrCnt_q <= hdrCnt_q + 4'h1;
      end
      for (int i = 0; i < fsc_pkg::HDR_BYTES; i++) begin
        hdr_q[i] <= hdrNext[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
    end else if (reqBeat && (hdrCnt_q == 4'h0)) begin
      meta_q <= reqMeta;
    end
  end

  // Response shifter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_q     <= 64'h0000_0000_0000_0000;
      rspLeft_q <= 4'h0;
    end else if (frameEnd && answer) begin
      rsp_q     <= rspBuild;
      rspLeft_q <= fsc_pkg::RSP_LEN;
    end else if (rspBeat) begin
      rsp_q     <= {rsp_q[55:0], 8'h00};
      rspLeft_q <= rspLeft_q - 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rspMeta <= '0;
    end else if (frameEnd && answer) begin
      rspMeta.cluster        <= fsc_pkg::CLUSTER_MEMORY;
      rspMeta.dstEndpoint    <= metaNow.srcEndpoint;
      rspMeta.srcEndpoint    <= fsc_pkg::ENDPOINT_DATA;
      rspMeta.indicatorFrame <= frameMode &&
          ((metaNow.srcEndpoint == fsc_pkg::ENDPOINT_DATA) || explicitMode);
    end
  end

  // No command of this block writes the store, so unknown ids cannot alter it
  fsc_store u_store (
    .core_clk  (core_clk),
    .rst       (rst),
    .wrEn      (appWrEn),
    .block     (appBlock),
    .index     (appIndex),
    .wrData    (appWrData),
    .rdData    (appRdData),
    .addrValid (appAddrValid)
  );

endmodule
`default_nettype wire

// ---- tb/fsc_cmd_access_chk.sv ----
// Port checker for fsc_cmd_access.
// Assumes it is bound to every fsc_cmd_access instance.
`timescale 1ns/1ps
`default_nettype none
module fsc_chk (
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire logic                   reqValid,
  input wire logic                   reqReady,
  input wire logic                   reqLast,
  input wire fsc_pkg::fsc_req_meta_s reqMeta,
  input wire logic                   explicitMode,
  input wire logic                   frameMode,
  input wire logic                   rspValid,
  input wire logic                   rspReady,
  input wire logic [7:0]             rspData,
  input wire logic                   rspLast,
  input wire fsc_pkg::fsc_rsp_meta_s rspMeta,
  input wire logic [6:0]             appBlock,
  input wire logic                   appAddrValid
);
  logic [3:0] cnt_q;
  always_ff @(posedge core_clk) begin
    if (rst) cnt_q <= 4'h0;
    else if (rspValid && rspReady) cnt_q <= rspLast ? 4'h0 : cnt_q + 4'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_ucEnd;
    reqValid && reqReady && reqLast && !reqMeta.broadcast
    && reqMeta.cluster == fsc_pkg::CLUSTER_MEMORY && reqMeta.dstEndpoint == fsc_pkg::ENDPOINT_DATA;
  endsequence
  sequence s_bcEnd;
    reqValid && reqReady && reqLast && reqMeta.broadcast;
  endsequence
  a_rsp_follows: assert property (s_ucEnd |=> rspValid && rspData[7])
    else $error("no response after unicast frame");
  a_bcast_quiet: assert property (s_bcEnd |=> !rspValid)
    else $error("response to broadcast");
  a_meta_route: assert property (s_ucEnd |=> rspMeta.cluster == fsc_pkg::CLUSTER_MEMORY
    && rspMeta.srcEndpoint == fsc_pkg::ENDPOINT_DATA && rspMeta.dstEndpoint == $past(reqMeta.srcEndpoint))
    else $error("response routed wrongly");
  a_indicator_mode: assert property (s_ucEnd |=> rspMeta.indicatorFrame == ($past(frameMode)
    && ($past(reqMeta.srcEndpoint) == fsc_pkg::ENDPOINT_DATA || $past(explicitMode))))
    else $error("indicator framing wrong");
  a_last_eighth: assert property (rspValid && rspLast |-> cnt_q == 4'h7)
    else $error("response length wrong");
  a_status_bits: assert property (rspValid && cnt_q == 4'h1 |-> rspData[7:1] == 7'h00)
    else $error("reserved status bits set");
  a_data_hold: assert property (rspValid && !rspReady |=> rspValid && $stable(rspData))
    else $error("response byte dropped");
  a_ready_block: assert property (rspValid |-> !reqReady)
    else $error("request taken while answering");
  a_app_range: assert property (!$past(rst) |-> appAddrValid == ($past(appBlock) < 7'd119))
    else $error("store range flag wrong");
endmodule
bind fsc_cmd_access fsc_chk u_chk (.core_clk(core_clk), .rst(rst), .reqValid(reqValid),
  .reqReady(reqReady), .reqLast(reqLast), .reqMeta(reqMeta), .explicitMode(explicitMode),
  .frameMode(frameMode), .rspValid(rspValid), .rspReady(rspReady), .rspData(rspData),
  .rspLast(rspLast), .rspMeta(rspMeta), .appBlock(appBlock), .appAddrValid(appAddrValid));
`default_nettype wire

// ---- tb/fsc_host.sv ----
// Requester model: sends command frames and drains responses.
// Assumes tasks are called just after a rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module fsc_host (
  input wire logic               core_clk,
  input wire logic               reqReady,
  input wire logic               rspValid,
  input wire logic [7:0]         rspData,
  input wire logic               rspLast,
  output logic                   reqValid,
  output logic [7:0]             reqData,
  output logic                   reqLast,
  output fsc_pkg::fsc_req_meta_s reqMeta,
  output logic                   rspReady
);
  initial begin
    reqValid = 1'b0;
    reqData = 8'h5A;
    reqLast = 1'b0;
    reqMeta = '0;
    rspReady = 1'b1;
  end
  // Header bytes leave most significant first
  task automatic send(input fsc_pkg::fsc_req_meta_s m, input logic [63:0] d, input int n);
    logic rdy;
    @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      reqMeta <= m;
      reqValid <= 1'b1;
      reqLast <= (i == n - 1);
      reqData <= d[63 - 8 * i -: 8];
      // Ready is judged on its settled value before the taking edge
      do begin
        @(negedge core_clk);
        rdy = reqReady;
        @(posedge core_clk);
      end while (!rdy);
    end
    reqValid <= 1'b0;
    reqLast <= 1'b0;
    reqData <= ~reqData;
  endtask
  task automatic recv(input bit slow, output logic [63:0] got, output logic lastOk);
    int k;
    k = 0;
    got = '0;
    lastOk = 1'b1;
    repeat (40) begin
      // Byte is taken at the next rising edge with these settled values
      @(negedge core_clk);
      if (rspValid && rspReady) begin
        got = {got[55:0], rspData};
        if (rspLast !== (k == 7)) lastOk = 1'b0;
        k++;
      end
      @(posedge core_clk);
      if (k == 8) break;
      rspReady <= slow ? ~rspReady : 1'b1;
    end
    rspReady <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for fsc_cmd_access.
// Assumes fsc_host as requester and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0, rst = 1'b1, explicitMode = 1'b0, frameMode = 1'b1;
  logic reqValid, reqLast, reqReady, rspValid, rspLast, rspReady, appAddrValid;
  logic appWrEn = 1'b0;
  logic [6:0] appBlock = 7'd0;
  logic [8:0] appIndex = 9'h000;
  logic [7:0] appWrData = 8'h00, reqData, rspData, appRdData;
  fsc_pkg::fsc_req_meta_s reqMeta;
  fsc_pkg::fsc_rsp_meta_s rspMeta;
  int fails = 0, total_checks = 0, cyc = 0;
  fsc_cmd_access u_dut (.core_clk(core_clk), .rst(rst), .reqValid(reqValid), .reqData(reqData),
    .reqLast(reqLast), .reqMeta(reqMeta), .reqReady(reqReady), .explicitMode(explicitMode),
    .frameMode(frameMode), .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast),
    .rspMeta(rspMeta), .rspReady(rspReady), .appWrEn(appWrEn), .appBlock(appBlock),
    .appIndex(appIndex), .appWrData(appWrData), .appRdData(appRdData),
    .appAddrValid(appAddrValid));
  fsc_host u_host (.core_clk(core_clk), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .rspLast(rspLast), .reqValid(reqValid), .reqData(reqData), .reqLast(reqLast),
    .reqMeta(reqMeta), .rspReady(rspReady));
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      close_out();
    end
  end
  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task t_app;
    appWrEn <= 1'b1;
    appBlock <= 7'd118;
    appIndex <= 9'h1FF;
    appWrData <= 8'hA5;
    @(posedge core_clk) appWrEn <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("app read", appRdData, 8'hA5);
    chk("app valid", appAddrValid, 1'b1);
    appBlock <= 7'd119;
    repeat (3) @(posedge core_clk);
    chk("app range", {appAddrValid, appRdData}, 9'h000);
    appBlock <= 7'd118;
    $display("t_app done");
  endtask
  task t_geom;
    logic [63:0] got;
    logic ok;
    for (int n = 8; n > 0; n -= 5) begin
      u_host.send({16'h0023, 8'hE6, 8'hE6, 1'b0}, 64'h0, n);
      u_host.recv(1'b0, got, ok);
      chk("geom last", ok, 1'b1);
      chk("geometry", got, 64'h8000_0077_0200_0000);
      chk("geom meta", rspMeta, {16'h0023, 8'hE6, 8'hE6, 1'b1});
    end
    $display("t_geom done");
  endtask
  task t_unknown;
    logic [63:0] got;
    logic [7:0] id;
    logic ok;
    for (int i = 0; i < 3; i++) begin
      id = (i == 2) ? 8'h7F : 8'(i + 1);
      explicitMode <= (i == 1);
      u_host.send({16'h0023, 8'hE6, 8'h10, 1'b0}, {id, 24'h000012, 32'h0034_0000}, 8);
      u_host.recv(1'b1, got, ok);
      chk("unk last", ok, 1'b1);
      chk("unknown", got, {id | 8'h80, 8'h01, 48'h0012_0034_0000});
      chk("unk meta", rspMeta, {16'h0023, 8'h10, 8'hE6, i == 1});
    end
    chk("store kept", appRdData, 8'hA5);
    $display("t_unknown done");
  endtask
  task t_quiet;
    // A wrong answer would show right after each frame's last beat
    u_host.send({16'h0023, 8'hE6, 8'hE6, 1'b1}, 64'h0, 8);
    @(negedge core_clk);
    chk("bcast silent", {rspValid, reqReady}, 2'b01);
    u_host.send({16'h0011, 8'hE6, 8'hE6, 1'b0}, 64'h0, 8);
    @(negedge core_clk);
    chk("cluster silent", {rspValid, reqReady}, 2'b01);
    u_host.send({16'h0023, 8'h01, 8'hE6, 1'b0}, 64'h0, 8);
    @(negedge core_clk);
    chk("endpoint silent", {rspValid, reqReady}, 2'b01);
    repeat (4) begin
      @(posedge core_clk);
      chk("silent", {rspValid, reqReady}, 2'b01);
    end
    $display("t_quiet done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_app();
    t_geom();
    t_unknown();
    t_quiet();
    close_out();
  end
endmodule
`default_nettype wire
